// ### rtl/input_rate_meter_sync_divider.sv
`timescale 1ns/1ps
module input_rate_meter_sync_divider
	import rate_meter_pkg::*;
#(
	parameter int GATE_CYCLES = GATE_CYC
)
(
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic [31:0]            hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	input  wire logic              sync_pin,
	input  wire logic [NUM_CH-1:0] det_pin,
	input  wire logic              hist_event,
	input  wire logic [BIN_W-1:0]  hist_bin,
	input  wire logic              hist_clear
);

	logic [NUM_CH:0]     edge_ff;
	logic [DT_W-1:0]     dead_ff;
	logic [7:0]          syncdiv_ff;
	logic [7:0]          sel_ff;
	logic [3:0]          refresh_ff;
	logic [CNT_W-1:0]    sync_rate_ff;
	logic [CNT_W-1:0]    ch_rate_ff;
	logic [CNT_W-1:0]    hist_rate_ff;
	logic [CNT_W-1:0]    total_ff;
	logic [CNT_W-1:0]    peak_ff;
	logic [BIN_W-1:0]    peak_pos_ff;
	logic [NUM_CH:0]     ev;
	logic                sync_ev;
	logic                sync_div_ev;
	logic [7:0]          div_cnt_ff;
	logic [2:0]          ch_ev_n;
	logic [PRE_W-1:0]    pre_sync_ff;
	logic [PRE_W-1:0]    pre_ch_ff;
	logic [CNT_W-1:0]    gate_cnt_ff;
	logic [CNT_W-1:0]    sync_acc_ff;
	logic [CNT_W-1:0]    ch_acc_ff;
	logic [CNT_W-1:0]    hist_acc_ff;
	logic [3:0]          upd_cnt_ff;
	logic                gate_end;
	logic                sel_hist;
	logic                wr_pend_ff;
	logic                rd_pend_ff;
	logic [7:0]          addr_ff;
	logic [CNT_W-1:0]    bins_ff [2**BIN_W];

	// Per-input conditioning, index NUM_CH is sync
	for (genvar i = 0; i <= NUM_CH; i++)
	begin : g_in
		input_conditioner u_cond (
			.hclk        (hclk),
			.hresetn     (hresetn),
			.pin_in      ((i == NUM_CH) ? sync_pin : det_pin[i % NUM_CH]),
			.rising_sel  (edge_ff[i]),
			.dead_cycles (dead_ff),
			.event_pulse (ev[i])
		);
	end
	assign sync_ev = ev[NUM_CH];

	// Event count of the selected input this cycle
	function automatic logic [2:0] sel_count(input logic [NUM_CH-1:0] e, input logic [7:0] s);
		logic [2:0] n;
		n = '0;
		if (s == SEL_SUM)
		begin
			for (int k = 0; k < NUM_CH; k++)
				n = n + {2'b00, e[k]};
		end
		else if (s < 8'(NUM_CH))
			n = {2'b00, e[s[1:0]]};
		return n;
	endfunction : sel_count

	assign ch_ev_n = sel_count(ev[NUM_CH-1:0], sel_ff);
	assign sel_hist = hist_event;

	////////////////////////////////////////////////////////////////
	// Sync divider
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			div_cnt_ff <= '0;
		else if (sync_ev)
			div_cnt_ff <= (div_cnt_ff + 8'h01 >= syncdiv_ff) ? 8'h00 : div_cnt_ff + 8'h01;
	end
	assign sync_div_ev = sync_ev && (div_cnt_ff + 8'h01 >= syncdiv_ff);

	////////////////////////////////////////////////////////////////
	// Gate timer
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			gate_cnt_ff <= '0;
		else if (gate_end)
			gate_cnt_ff <= '0;
		else
			gate_cnt_ff <= gate_cnt_ff + 1'b1;
	end
	assign gate_end = (gate_cnt_ff == CNT_W'(GATE_CYCLES - 1));

	// Prescalers and gated accumulators
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pre_sync_ff <= '0;
			pre_ch_ff   <= '0;
			sync_acc_ff <= '0;
			ch_acc_ff   <= '0;
			hist_acc_ff <= '0;
		end
		else
		begin
			pre_sync_ff <= pre_sync_ff + PRE_W'(sync_div_ev);
			pre_ch_ff   <= pre_ch_ff + PRE_W'(ch_ev_n);
			if (gate_end)
			begin
				sync_acc_ff <= '0;
				ch_acc_ff   <= '0;
				hist_acc_ff <= '0;
			end
			else
			begin
				if (pre_sync_ff[PRE_LOG2-1:0] + PRE_LOG2'(sync_div_ev) < pre_sync_ff[PRE_LOG2-1:0])
					sync_acc_ff <= sync_acc_ff + 1'b1;
				if ({1'b0, pre_ch_ff[PRE_LOG2-1:0]} + {1'b0, ch_ev_n} > 4'(2**PRE_LOG2 - 1)
					&& pre_ch_ff[PRE_LOG2-1:0] + PRE_LOG2'(ch_ev_n) < 3'(2**PRE_LOG2 - 1) + 3'h1)
					ch_acc_ff <= ch_acc_ff + 1'b1;
				else if ({1'b0, pre_ch_ff[PRE_LOG2-1:0]} + {1'b0, ch_ev_n} > 4'(2**PRE_LOG2 - 1))
					ch_acc_ff <= ch_acc_ff + 1'b1;
				if (sel_hist)
					hist_acc_ff <= hist_acc_ff + 1'b1;
			end
		end
	end

	// Publish rates on the refresh interval
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			upd_cnt_ff   <= '0;
			sync_rate_ff <= '0;
			ch_rate_ff   <= '0;
			hist_rate_ff <= '0;
		end
		else if (gate_end)
		begin
			if (upd_cnt_ff + 4'h1 >= refresh_ff)
			begin
				upd_cnt_ff   <= '0;
				sync_rate_ff <= CNT_W'((sync_acc_ff << PRE_LOG2) * GATE_PER_S * syncdiv_ff);
				ch_rate_ff   <= CNT_W'((ch_acc_ff << PRE_LOG2) * GATE_PER_S);
				hist_rate_ff <= CNT_W'(hist_acc_ff * GATE_PER_S);
			end
			else
				upd_cnt_ff <= upd_cnt_ff + 4'h1;
		end
	end

	// Histogram statistics: total, peak, peak position
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			total_ff    <= '0;
			peak_ff     <= '0;
			peak_pos_ff <= '0;
			for (int b = 0; b < 2**BIN_W; b++)
				bins_ff[b] <= '0;
		end
		else if (hist_clear)
		begin
			total_ff    <= '0;
			peak_ff     <= '0;
			peak_pos_ff <= '0;
			for (int b = 0; b < 2**BIN_W; b++)
				bins_ff[b] <= '0;
		end
		else if (sel_hist)
		begin
			bins_ff[hist_bin] <= bins_ff[hist_bin] + 1'b1;
			total_ff          <= total_ff + 1'b1;
			if (bins_ff[hist_bin] + 1'b1 > peak_ff)
			begin
				peak_ff     <= bins_ff[hist_bin] + 1'b1;
				peak_pos_ff <= hist_bin;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// AHB-Lite slave, zero wait states
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_ff <= 1'b0;
			rd_pend_ff <= 1'b0;
			addr_ff    <= '0;
		end
		else if (hready)
		begin
			wr_pend_ff <= hsel && htrans[1] && hwrite;
			rd_pend_ff <= hsel && htrans[1] && !hwrite;
			addr_ff    <= haddr[7:0];
		end
	end

	// Control register writes
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			edge_ff    <= RST_EDGE;
			dead_ff    <= RST_DEAD;
			syncdiv_ff <= RST_SYNCDIV;
			sel_ff     <= SEL_SUM;
			refresh_ff <= RST_REFRESH;
		end
		else if (wr_pend_ff)
		begin
			unique case (addr_ff)
				OFS_EDGE:    edge_ff    <= hwdata[NUM_CH:0];
				OFS_DEAD:    dead_ff    <= hwdata[DT_W-1:0];
				OFS_SYNCDIV: syncdiv_ff <= (hwdata[7:0] == 8'h00) ? 8'h01 : hwdata[7:0];
				OFS_SEL:     sel_ff     <= hwdata[7:0];
				OFS_REFRESH: refresh_ff <= (hwdata[3:0] == 4'h0) ? 4'h1 :
					(hwdata[3:0] > MAX_REFRESH) ? MAX_REFRESH : hwdata[3:0];
				default:     ;
			endcase
		end
	end

	// Read data register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= '0;
		else if (hready && hsel && htrans[1] && !hwrite)
		begin
			unique case (haddr[7:0])
				OFS_EDGE:    hrdata <= 32'(edge_ff);
				OFS_DEAD:    hrdata <= 32'(dead_ff);
				OFS_SYNCDIV: hrdata <= 32'(syncdiv_ff);
				OFS_SEL:     hrdata <= 32'(sel_ff);
				OFS_REFRESH: hrdata <= 32'(refresh_ff);
				OFS_SYNCRT:  hrdata <= sync_rate_ff;
				OFS_CHRT:    hrdata <= ch_rate_ff;
				OFS_HISTRT:  hrdata <= hist_rate_ff;
				OFS_TOTAL:   hrdata <= total_ff;
				OFS_PEAK:    hrdata <= peak_ff;
				OFS_PEAKPOS: hrdata <= 32'(peak_pos_ff);
				default:     hrdata <= '0;
			endcase
		end
	end

	p_gate_len: assert property (@(posedge hclk) disable iff (!hresetn)
		gate_end |=> gate_cnt_ff == '0)
		else $error("gate did not restart");
	p_acc_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		gate_end |=> sync_acc_ff == '0 && ch_acc_ff == '0)
		else $error("accumulators not cleared");
	p_div_one: assert property (@(posedge hclk) disable iff (!hresetn)
		syncdiv_ff == 8'h01 |-> sync_div_ev == sync_ev)
		else $error("undivided sync lost events");
	p_sum_sel: assert property (@(posedge hclk) disable iff (!hresetn)
		sel_ff == SEL_SUM && ev[0] |-> ch_ev_n != '0)
		else $error("sum missed event");
	p_refresh_rng: assert property (@(posedge hclk) disable iff (!hresetn)
		refresh_ff >= 4'h1 && refresh_ff <= MAX_REFRESH)
		else $error("refresh out of range");
	p_total_inc: assert property (@(posedge hclk) disable iff (!hresetn)
		sel_hist && !hist_clear |=> total_ff == $past(total_ff) + 1'b1)
		else $error("total not counted");
	p_edge_sel: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_pend_ff && addr_ff == OFS_EDGE |=> edge_ff == $past(hwdata[NUM_CH:0]))
		else $error("edge select not stored");
	p_peak_ge: assert property (@(posedge hclk) disable iff (!hresetn)
		peak_ff <= total_ff)
		else $error("peak above total");

endmodule : input_rate_meter_sync_divider

// ### rtl/rate_meter_pkg.sv
package rate_meter_pkg;

	// Channel count and widths
	localparam int  NUM_CH      = 4;
	localparam int  CNT_W       = 32;
	localparam int  DT_W        = 8;
	localparam int  PRE_W       = 4;
	localparam int  BIN_W       = 10;

	// Clock and timing
	localparam int  CLK_MHZ     = 125;
	localparam int  GATE_MS     = 100;
	localparam int  GATE_CYC    = GATE_MS * CLK_MHZ * 1000;
	localparam int  GATE_PER_S  = 1000 / GATE_MS;

	// Prescaler ratio log2
	localparam int  PRE_LOG2    = 3;

	// Register byte offsets
	localparam logic [7:0] OFS_EDGE    = 8'h00;
	localparam logic [7:0] OFS_DEAD    = 8'h04;
	localparam logic [7:0] OFS_SYNCDIV = 8'h08;
	localparam logic [7:0] OFS_SEL     = 8'h0c;
	localparam logic [7:0] OFS_REFRESH = 8'h10;
	localparam logic [7:0] OFS_SYNCRT  = 8'h14;
	localparam logic [7:0] OFS_CHRT    = 8'h18;
	localparam logic [7:0] OFS_HISTRT  = 8'h1c;
	localparam logic [7:0] OFS_TOTAL   = 8'h20;
	localparam logic [7:0] OFS_PEAK    = 8'h24;
	localparam logic [7:0] OFS_PEAKPOS = 8'h28;

	// Reset values and refresh limit
	localparam logic [NUM_CH:0]  RST_EDGE    = '1;
	localparam logic [DT_W-1:0]  RST_DEAD    = '0;
	localparam logic [7:0]       RST_SYNCDIV = 8'h01;
	localparam logic [7:0]       SEL_SUM     = 8'hff;
	localparam logic [3:0]       RST_REFRESH = 4'h1;
	localparam logic [3:0]       MAX_REFRESH = 4'ha;

endpackage : rate_meter_pkg

// ### rtl/input_conditioner.sv
`timescale 1ns/1ps
module input_conditioner
	import rate_meter_pkg::*;
(
	input  wire logic            hclk,
	input  wire logic            hresetn,
	input  wire logic            pin_in,
	input  wire logic            rising_sel,
	input  wire logic [DT_W-1:0] dead_cycles,
	output logic                 event_pulse
);

	logic       sync1_ff;
	logic       sync2_ff;
	logic       prev_ff;
	logic [DT_W-1:0] dead_ff;
	logic       raw_edge;

	// Two-stage synchroniser
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
			prev_ff  <= 1'b0;
		end
		else
		begin
			sync1_ff <= pin_in;
			sync2_ff <= sync1_ff;
			prev_ff  <= sync2_ff;
		end
	end

	// Edge select: 1 rising, 0 falling
	assign raw_edge = rising_sel ? (sync2_ff & ~prev_ff) : (~sync2_ff & prev_ff);

	// Dead time lockout after each accepted event
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dead_ff     <= '0;
			event_pulse <= 1'b0;
		end
		else
		begin
			event_pulse <= raw_edge && (dead_ff == '0);
			if (raw_edge && dead_ff == '0)
				dead_ff <= dead_cycles;
			else if (dead_ff != '0)
				dead_ff <= dead_ff - 1'b1;
		end
	end

	p_dead_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		event_pulse && dead_cycles != '0 |=> !event_pulse)
		else $error("event inside dead time");

endmodule : input_conditioner

// ### bench/host_meter_reader.sv
`timescale 1ns/1ps
module host_meter_reader
(
	input  wire logic        hclk,
	input  wire logic        hreadyout,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata
);
	logic hung = 1'b0;

	// Bus idle at time zero
	initial
	begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
	end

	// Smallest ratio keeping the divided sync under 78 MHz
	function automatic logic [7:0] pick_div(input int khz, input bit periodic);
		int d;
		d = 1;
		while (periodic && khz / d >= 78000)
			d++;
		return d[7:0];
	endfunction : pick_div

	// One single word transfer, entered just after a rising edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		hsize <= 3'b010;
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 50);
		htrans <= 2'b00;
		hwdata <= d;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 100);
		q = hrdata;
		if (n >= 50)
			hung = 1'b1;
	endtask : xfer
endmodule : host_meter_reader

// ### bench/test_input_rate_meter_sync_divider.sv
`timescale 1ns/1ps
module test_input_rate_meter_sync_divider;
	import rate_meter_pkg::*;
	localparam int GC = 160;
	logic              hclk = 1'b0;
	logic              hresetn = 1'b0;
	logic              hsel;
	logic [31:0]       haddr;
	logic [1:0]        htrans;
	logic              hwrite;
	logic [2:0]        hsize;
	logic [31:0]       hwdata;
	logic [31:0]       hrdata;
	logic              hreadyout;
	logic              hresp;
	logic              sync_pin = 1'b0;
	logic [NUM_CH-1:0] det_pin = '0;
	logic              hist_event = 1'b0;
	logic [BIN_W-1:0]  hist_bin = '0;
	logic              hist_clear = 1'b0;
	logic [31:0]       rnd = 32'h5b52338f;
	logic [31:0]       q;
	logic [31:0]       cyc = 32'h0;
	logic [3:0]        mask = 4'h0;
	logic              sync_en = 1'b0;
	logic [7:0]        s;
	logic [7:0]        d;
	logic [BIN_W-1:0]  pk;
	int                n_errors = 0;
	int                total_checks = 0;
	logic [7:0]  divs [4] = '{8'h01, 8'h02, 8'h05, 8'h0a};
	logic [7:0]  ra [6] = '{OFS_EDGE, OFS_DEAD, OFS_SYNCDIV, OFS_SEL, OFS_REFRESH, 8'h40};
	logic [31:0] rv [6] = '{32'(RST_EDGE), 32'(RST_DEAD), 32'(RST_SYNCDIV),
		32'(SEL_SUM), 32'(RST_REFRESH), 32'h0};

	always #4 hclk = ~hclk;

	input_rate_meter_sync_divider #(.GATE_CYCLES(GC)) i_dut
	(
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.sync_pin(sync_pin), .det_pin(det_pin), .hist_event(hist_event),
		.hist_bin(hist_bin), .hist_clear(hist_clear)
	);

	host_meter_reader i_host
	(
		.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata)
	);

	////////////////////////////////////////
	// Sync toggles every cycle, channels pulse every 4 staggered by one
	always @(posedge hclk)
	begin
		cyc <= cyc + 1;
		sync_pin <= sync_en & ~sync_pin;
		for (int i = 0; i < NUM_CH; i++)
			det_pin[i] <= mask[i] & (((cyc[1:0] - 2'(i)) & 2'b10) == 2'b00);
	end

	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction : xs

	// Expected channel cps for an enable mask and selector code
	function automatic logic [31:0] exp_ch(input logic [3:0] m, input logic [7:0] sl);
		if (sl == SEL_SUM)
			return 32'($countones(m)) * (GC / 4) * GATE_PER_S;
		return (sl < NUM_CH && m[sl[1:0]]) ? (GC / 4) * GATE_PER_S : 32'h0;
	endfunction : exp_ch

	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// Bus access through the host model, stop on a hang
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] dt);
		i_host.xfer(w, a, dt, q);
		if (i_host.hung)
		begin
			n_errors++;
			report_and_stop();
		end
	endtask : acc

	////////////////////////////////////////
	// Main sequence
	initial
	begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		for (int i = 0; i < 6; i++)
		begin
			acc(0, ra[i], 0);
			chk(q, rv[i]);
		end
		acc(1, 8'h40, 32'hdead);
		acc(0, 8'h40, 0);
		chk(q, 0);
		acc(1, OFS_SYNCDIV, 0);
		acc(0, OFS_SYNCDIV, 0);
		chk(q, 1);
		acc(1, OFS_REFRESH, 32'hf);
		acc(0, OFS_REFRESH, 0);
		chk(q, 32'(MAX_REFRESH));
		acc(1, OFS_REFRESH, 1);
		sync_en <= 1'b1;
		for (int k = 0; k < 7; k++)
		begin
			rnd = xs(rnd);
			mask <= (k == 0) ? 4'hf : rnd[7:4];
			s = (k == 0 || rnd[3]) ? SEL_SUM : 8'(rnd[2:0]);
			d = i_host.pick_div(125000 / 2, 1'b1) * divs[rnd[9:8]];
			acc(1, OFS_SEL, s);
			acc(1, OFS_SYNCDIV, d);
			acc(1, OFS_EDGE, {27'h0, {5{rnd[10]}}});
			repeat (4 * GC) @(posedge hclk);
			acc(0, OFS_SYNCRT, 0);
			chk(q, (GC / 2) * GATE_PER_S);
			acc(0, OFS_CHRT, 0);
			chk(q, exp_ch((k == 0) ? 4'hf : rnd[7:4], s));
		end
		// Dead time longer than a gate leaves at most one prescaled count
		acc(1, OFS_SYNCDIV, 1);
		acc(1, OFS_DEAD, 32'hff);
		repeat (4 * GC) @(posedge hclk);
		acc(0, OFS_SYNCRT, 0);
		chk(32'(q <= 8 * GATE_PER_S), 1);
		acc(1, OFS_DEAD, 0);
		// Histogram: peak bin three times, bins pk^1 and pk^2 once each
		rnd = xs(rnd);
		pk = rnd[BIN_W-1:0];
		for (int i = 0; i < 5; i++)
		begin
			hist_event <= 1'b1;
			hist_bin <= (i % 2 == 1) ? pk ^ BIN_W'(i / 2 + 1) : pk;
			@(posedge hclk);
		end
		hist_event <= 1'b0;
		repeat (2 * GC) @(posedge hclk);
		acc(0, OFS_TOTAL, 0);
		chk(q, 5);
		acc(0, OFS_PEAK, 0);
		chk(q, 3);
		acc(0, OFS_PEAKPOS, 0);
		chk(q, 32'(pk));
		hist_clear <= 1'b1;
		@(posedge hclk);
		hist_clear <= 1'b0;
		repeat (4) @(posedge hclk);
		acc(0, OFS_TOTAL, 0);
		chk(q, 0);
		chk(32'(hresp), 0);
		report_and_stop();
	end
endmodule : test_input_rate_meter_sync_divider
